// ### include/atc_regs.svh
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
// Byte offsets on the register bus
`define ATC_ADDR_W 6
`define ATC_OFF_CTRL 6'h00
`define ATC_OFF_GCTRL 6'h04
`define ATC_OFF_CMPA 6'h08
`define ATC_OFF_CMPB 6'h0C
`define ATC_OFF_TOP 6'h10
`define ATC_OFF_CNT 6'h14
`define ATC_OFF_FLAG 6'h18
`define ATC_OFF_MASK 6'h1C
`define ATC_OFF_PLL 6'h20
// timer_control_reg fields
`define ATC_CTRL_CTC 7
`define ATC_CTRL_PWMA 6
`define ATC_CTRL_COMA_LO 4
`define ATC_CTRL_CS_LO 0
// general_timer_control_reg fields
`define ATC_GCTRL_PWMB 6
`define ATC_GCTRL_COMB_LO 4
`define ATC_GCTRL_PSR 1
// timer_flag_reg and timer_mask_reg fields
`define ATC_FLAG_A 2
`define ATC_FLAG_B 1
`define ATC_FLAG_WRAP 0
`define ATC_FLAG_MASK 8'h07
// pll_control_status_reg fields
`define ATC_PLL_LSM 3
`define ATC_PLL_FCS 2
`define ATC_PLL_EN 1
`define ATC_PLL_LOCK 0
`define ATC_PLL_WMASK 8'h0E
// Reset values
`define ATC_RST_REG 8'h00
`define ATC_RST_TOP 8'hFF
// Counter landmarks
`define ATC_CNT_BOTTOM 8'h00
`define ATC_CNT_ONE 8'h01
`define ATC_CNT_MAX 8'hFF
// Prescaler: 2**14 = 16384 is the deepest division
`define ATC_DIV_LOG 14
`define ATC_SEL_W 4
// Fast peripheral clock rates in MHz
`define ATC_PCK_FAST_MHZ 64
`define ATC_PCK_SLOW_MHZ 32
// Bus responses
`define ATC_RESP_OKAY 2'h0
`define ATC_RESP_SLVERR 2'h2
`endif

// ### include/atc_pkg.sv
package atc_pkg;
  typedef enum logic [1:0] {
    ATC_COM_OFF = 2'h0,
    ATC_COM_TOGGLE = 2'h1,
    ATC_COM_CLEAR = 2'h2,
    ATC_COM_SET = 2'h3
  } atc_com_t;
  typedef logic [7:0] atc_byte_t;
endpackage : atc_pkg

// ### core/atc_prescaler.sv
`timescale 1ns/1ps
`include "atc_regs.svh"
module atc_prescaler #(
  parameter int DIV_LOG = `ATC_DIV_LOG,
  parameter int SEL_W = `ATC_SEL_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic src_pulse,
  input wire logic presc_clr,
  input wire logic [SEL_W-1:0] clk_sel,
  output logic tick
);
  initial begin
    if (DIV_LOG < 1 || DIV_LOG + 1 > (1 << SEL_W) - 1) begin
      $error("atc_prescaler: select width cannot reach the division depth");
    end
  end

  logic [DIV_LOG-1:0] div_r;
  logic [DIV_LOG-1:0] msk;

  // Select n>0 divides by 2**(n-1): low n-1 bits must all be ones
  function automatic logic [DIV_LOG-1:0] atc_div_mask(input logic [SEL_W-1:0] sel);
    logic [DIV_LOG-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_LOG; i++) begin
      if (i + 1 < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : atc_div_mask

  assign msk = atc_div_mask(clk_sel);
  assign tick = src_pulse && (clk_sel != '0) && ((div_r & msk) == msk);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= '0;
    end else if (presc_clr) begin
      div_r <= '0;
    end else if (src_pulse) begin
      div_r <= div_r + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_stop_no_tick: assert property (clk_sel == '0 |-> !tick)
    else $error("prescaler ticks while stopped");
  chk_presc_clear: assert property (presc_clr |=> div_r == '0)
    else $error("prescaler not cleared by reset strobe");
endmodule : atc_prescaler

// ### core/atc_core.sv
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "atc_regs.svh"
module atc_core #(
  parameter int FAST_MHZ = `ATC_PCK_FAST_MHZ
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [`ATC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ATC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fast_peripheral_clock,
  input wire logic pll_locked,
  output logic pll_enable,
  output logic pll_low_speed,
  input wire logic int_global_en,
  input wire logic [2:0] int_ack,
  output logic irq,
  output logic wave_out_a,
  output logic wave_out_a_oe,
  output logic wave_out_a_n,
  output logic wave_out_a_n_oe,
  output logic wave_out_b,
  output logic wave_out_b_oe,
  output logic wave_out_b_n,
  output logic wave_out_b_n_oe
);
  initial begin
    if (FAST_MHZ != `ATC_PCK_FAST_MHZ && FAST_MHZ != `ATC_PCK_SLOW_MHZ) begin
      $error("atc_core: fast clock must be 64 or 32 MHz");
    end
  end

  localparam int CFG_W = 36;

  function automatic logic atc_hit(input logic [`ATC_ADDR_W-1:0] a,
                                   input logic [`ATC_ADDR_W-1:0] off);
    return a == off;
  endfunction : atc_hit

  // Next true level of a wave output on a timer tick
  function automatic logic atc_wave_nxt(input atc_pkg::atc_com_t com, input logic pwm,
                                        input logic mtch, input logic at_one,
                                        input logic cur);
    logic v;
    v = cur;
    if (pwm) begin
      if (mtch) begin
        v = (com == atc_pkg::ATC_COM_SET);
      end else if (at_one) begin
        v = (com != atc_pkg::ATC_COM_SET);
      end
    end else if (mtch) begin
      case (com)
        atc_pkg::ATC_COM_TOGGLE: v = !cur;
        atc_pkg::ATC_COM_CLEAR: v = 1'b0;
        atc_pkg::ATC_COM_SET: v = 1'b1;
        default: v = cur;
      endcase
    end
    return v;
  endfunction : atc_wave_nxt

  // Bus-side registers
  atc_pkg::atc_byte_t ctrl_r, gctrl_r, cmpa_r, cmpb_r, top_r, cnt_wdata_r, mask_r;
  logic [3:0] pll_r;
  logic [2:0] flag_r;
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r, psr_wr_r, cnt_wr_r;
  logic [`ATC_ADDR_W-1:0] aw_addr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic wr_go, wr_en, mapped_w, mapped_r;
  logic [7:0] rd_nxt;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_en = wr_go && wstrb0_r;
  assign mapped_w = aw_addr_r <= `ATC_OFF_PLL && aw_addr_r[1:0] == 2'h0;
  assign mapped_r = s_axi_araddr <= `ATC_OFF_PLL && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `ATC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped_w ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Software copies read back at once; timing logic sees synchronised copies
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `ATC_RST_REG;
      gctrl_r <= `ATC_RST_REG;
      cmpa_r <= `ATC_RST_REG;
      cmpb_r <= `ATC_RST_REG;
      top_r <= `ATC_RST_TOP;
      cnt_wdata_r <= `ATC_RST_REG;
      mask_r <= `ATC_RST_REG;
      pll_r <= 4'h0;
      psr_wr_r <= 1'b0;
      cnt_wr_r <= 1'b0;
    end else begin
      psr_wr_r <= wr_en && atc_hit(aw_addr_r, `ATC_OFF_GCTRL) && wdata_r[`ATC_GCTRL_PSR];
      cnt_wr_r <= wr_en && atc_hit(aw_addr_r, `ATC_OFF_CNT);
      if (wr_en) begin
        case (aw_addr_r)
          `ATC_OFF_CTRL: ctrl_r <= wdata_r;
          `ATC_OFF_GCTRL: gctrl_r <= wdata_r & 8'h70;
          `ATC_OFF_CMPA: cmpa_r <= wdata_r;
          `ATC_OFF_CMPB: cmpb_r <= wdata_r;
          `ATC_OFF_TOP: top_r <= wdata_r;
          `ATC_OFF_CNT: cnt_wdata_r <= wdata_r;
          `ATC_OFF_MASK: mask_r <= wdata_r & `ATC_FLAG_MASK;
          `ATC_OFF_PLL: pll_r <= 4'(wdata_r & `ATC_PLL_WMASK);
          default: ;
        endcase
      end
    end
  end
  assign pll_enable = pll_r[`ATC_PLL_EN];
  assign pll_low_speed = pll_r[`ATC_PLL_LSM];

  // Pin inputs: two flops before use; third flop only for edge detection
  logic pck_s1_r, pck_s2_r, pck_s3_r, lock_s1_r, lock_s2_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pck_s1_r <= 1'b0;
      pck_s2_r <= 1'b0;
      pck_s3_r <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      pck_s1_r <= fast_peripheral_clock;
      pck_s2_r <= pck_s1_r;
      pck_s3_r <= pck_s2_r;
      lock_s1_r <= pll_locked;
      lock_s2_r <= lock_s1_r;
    end
  end

  // Input synchroniser stages for configuration and strobes
  logic [CFG_W-1:0] cfg_w, cfg_s1_r, cfg_s2_r;
  logic psr_s1_r, psr_s2_r, cld_s1_r, cld_s2_r;
  assign cfg_w = {pll_r[`ATC_PLL_FCS], ctrl_r, gctrl_r[6:4], cmpa_r, cmpb_r, top_r};
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_s1_r <= {1'b0, `ATC_RST_REG, 3'h0, `ATC_RST_REG, `ATC_RST_REG, `ATC_RST_TOP};
      cfg_s2_r <= {1'b0, `ATC_RST_REG, 3'h0, `ATC_RST_REG, `ATC_RST_REG, `ATC_RST_TOP};
      psr_s1_r <= 1'b0;
      psr_s2_r <= 1'b0;
      cld_s1_r <= 1'b0;
      cld_s2_r <= 1'b0;
    end else begin
      cfg_s1_r <= cfg_w;
      cfg_s2_r <= cfg_s1_r;
      psr_s1_r <= psr_wr_r;
      psr_s2_r <= psr_s1_r;
      cld_s1_r <= cnt_wr_r;
      cld_s2_r <= cld_s1_r;
    end
  end

  logic fcs, ctc, pwm_a, pwm_b, pwm_any, tick, src_pulse, top_hit, clr_top, wrap;
  logic mtch_a, mtch_b;
  atc_pkg::atc_com_t com_a, com_b;
  atc_pkg::atc_byte_t cmpa_s, cmpb_s, top_s, cmpa_act_r, cmpb_act_r, cnt_r, cnt_nxt;
  // Layout: select 35, ctrl 34:27, gctrl[6:4] 26:24, cmp a 23:16, cmp b 15:8, top 7:0
  assign fcs = cfg_s2_r[35];
  assign ctc = cfg_s2_r[34];
  assign pwm_a = cfg_s2_r[33];
  assign com_a = atc_pkg::atc_com_t'(cfg_s2_r[32:31]);
  assign pwm_b = cfg_s2_r[26];
  assign com_b = atc_pkg::atc_com_t'(cfg_s2_r[25:24]);
  assign cmpa_s = cfg_s2_r[23:16];
  assign cmpb_s = cfg_s2_r[15:8];
  assign top_s = cfg_s2_r[7:0];
  assign pwm_any = pwm_a || pwm_b;
  assign src_pulse = fcs ? (pck_s2_r && !pck_s3_r) : 1'b1;

  atc_prescaler #(
    .DIV_LOG(`ATC_DIV_LOG),
    .SEL_W(`ATC_SEL_W)
  ) u_presc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .src_pulse(src_pulse),
    .presc_clr(psr_s2_r),
    .clk_sel(cfg_s2_r[`ATC_SEL_W+26:27]),
    .tick(tick)
  );

  assign top_hit = cnt_r == top_s;
  assign clr_top = ctc || pwm_any;
  assign mtch_a = tick && cnt_r == cmpa_act_r;
  assign mtch_b = tick && cnt_r == cmpb_act_r;
  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    if (clr_top && top_hit) begin
      cnt_nxt = `ATC_CNT_BOTTOM;
    end
  end
  assign wrap = tick && cnt_nxt == `ATC_CNT_BOTTOM &&
                (cnt_r == `ATC_CNT_MAX || (pwm_any && top_hit));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= `ATC_CNT_BOTTOM;
    end else if (cld_s2_r) begin
      cnt_r <= cnt_wdata_r;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  // Held compare values load at top in PWM, directly otherwise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmpa_act_r <= `ATC_RST_REG;
      cmpb_act_r <= `ATC_RST_REG;
    end else begin
      if (!pwm_a || (tick && top_hit)) begin
        cmpa_act_r <= cmpa_s;
      end
      if (!pwm_b || (tick && top_hit)) begin
        cmpb_act_r <= cmpb_s;
      end
    end
  end

  // One tick of dead time: complement falls at bottom a tick before the true output rises; both flip together on a match
  logic wa_r, wa_n_r, wb_r, wb_n_r, at_one, at_zero;
  assign at_one = cnt_nxt == `ATC_CNT_ONE;
  assign at_zero = cnt_nxt == `ATC_CNT_BOTTOM;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wa_r <= 1'b0;
      wa_n_r <= 1'b0;
      wb_r <= 1'b0;
      wb_n_r <= 1'b0;
    end else if (tick) begin
      wa_r <= atc_wave_nxt(com_a, pwm_a, mtch_a, at_one, wa_r);
      wb_r <= atc_wave_nxt(com_b, pwm_b, mtch_b, at_one, wb_r);
      wa_n_r <= mtch_a ? 1'b1 : (at_zero ? 1'b0 : wa_n_r);
      wb_n_r <= mtch_b ? 1'b1 : (at_zero ? 1'b0 : wb_n_r);
    end
  end
  assign wave_out_a = wa_r;
  assign wave_out_b = wb_r;
  assign wave_out_a_n = wa_n_r;
  assign wave_out_b_n = wb_n_r;
  assign wave_out_a_oe = com_a != atc_pkg::ATC_COM_OFF;
  assign wave_out_b_oe = com_b != atc_pkg::ATC_COM_OFF;
  assign wave_out_a_n_oe = pwm_a && com_a == atc_pkg::ATC_COM_TOGGLE;
  assign wave_out_b_n_oe = pwm_b && com_b == atc_pkg::ATC_COM_TOGGLE;

  // Output synchroniser stages for count and flag events
  logic [2:0] ev_o1_r, ev_o2_r, flag_clr;
  atc_pkg::atc_byte_t cnt_o1_r, cnt_o2_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_o1_r <= 3'h0;
      ev_o2_r <= 3'h0;
      cnt_o1_r <= `ATC_CNT_BOTTOM;
      cnt_o2_r <= `ATC_CNT_BOTTOM;
    end else begin
      ev_o1_r <= {mtch_a, mtch_b, wrap};
      ev_o2_r <= ev_o1_r;
      cnt_o1_r <= cnt_r;
      cnt_o2_r <= cnt_o1_r;
    end
  end

  assign flag_clr = int_ack |
    ((wr_en && atc_hit(aw_addr_r, `ATC_OFF_FLAG)) ? wdata_r[2:0] : 3'h0);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | ev_o2_r;
    end
  end
  assign irq = int_global_en && |(flag_r & mask_r[2:0]);

  always_comb begin
    case (s_axi_araddr)
      `ATC_OFF_CTRL: rd_nxt = ctrl_r;
      `ATC_OFF_GCTRL: rd_nxt = gctrl_r;
      `ATC_OFF_CMPA: rd_nxt = cmpa_r;
      `ATC_OFF_CMPB: rd_nxt = cmpb_r;
      `ATC_OFF_TOP: rd_nxt = top_r;
      `ATC_OFF_CNT: rd_nxt = cnt_o2_r;
      `ATC_OFF_FLAG: rd_nxt = {5'h00, flag_r};
      `ATC_OFF_MASK: rd_nxt = mask_r;
      `ATC_OFF_PLL: rd_nxt = {4'h0, pll_r[3:1], lock_s2_r};
      default: rd_nxt = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `ATC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_nxt};
      rresp_r <= mapped_r ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_ctc_top_clear: assert property (tick && ctc && top_hit && !cld_s2_r |=> cnt_r == 8'h00)
    else $error("counter not cleared after top match");
  chk_pwm_top_restart: assert property (tick && pwm_any && top_hit && !cld_s2_r
                                        |=> cnt_r == 8'h00)
    else $error("pwm counter did not restart at top");
  chk_wrap_flag_delay: assert property (wrap |-> ##3 flag_r[`ATC_FLAG_WRAP])
    else $error("wrap flag not set three cycles after wrap");
  chk_match_a_flag: assert property (mtch_a |-> ##3 flag_r[`ATC_FLAG_A])
    else $error("match a flag not set after match");
  chk_inv_normal_off: assert property (!pwm_a |-> !wave_out_a_n_oe)
    else $error("inverted output a driven in normal mode");
  chk_inv_off_b: assert property (!pwm_b |-> !wave_out_b_n_oe)
    else $error("inverted output b driven in normal mode");
  chk_cfg_sync_delay: assert property (##2 cfg_s2_r == $past(cfg_w, 2))
    else $error("configuration not two stages late");
  chk_readback_cmpa: assert property (wr_en && aw_addr_r == `ATC_OFF_CMPA
                                      |=> cmpa_r == $past(wdata_r))
    else $error("compare a write not read back");
  chk_pwm_hold_a: assert property (pwm_a && !(tick && top_hit) |=> $stable(cmpa_act_r))
    else $error("held compare a loaded away from top");
  chk_irq_gate: assert property (irq |-> int_global_en && (flag_r & mask_r[2:0]) != 3'h0)
    else $error("irq without enabled flag");
  cov_wrap_flag: cover property (wrap ##3 flag_r[`ATC_FLAG_WRAP]);
  cov_pwm_cycle: cover property (pwm_a && tick && top_hit);
  cov_fast_tick: cover property (fcs && tick);
  cov_bus_write: cover property (wr_go);
endmodule : atc_core

// ### verification/atc_pll_model.sv
`timescale 1ns/1ps
module atc_pll_model #(
  parameter int LOCK_NS = 3000
) (
  input wire logic pll_enable,
  input wire logic pll_low_speed,
  output logic fast_peripheral_clock,
  output logic pll_locked
);
  // Stands still while the PLL is off; half rate in low speed mode
  initial begin
    fast_peripheral_clock = 1'b0;
    forever begin
      if (pll_enable === 1'b1) begin
        #(pll_low_speed ? 40 : 20);
        fast_peripheral_clock = ~fast_peripheral_clock;
      end else begin
        fast_peripheral_clock = 1'b0;
        @(pll_enable);
      end
    end
  end
  always begin
    pll_locked = 1'b0;
    wait (pll_enable === 1'b1);
    #(LOCK_NS);
    pll_locked = pll_enable;
    wait (pll_enable !== 1'b1);
  end
endmodule : atc_pll_model

// ### verification/atc_core_tb.sv
`timescale 1ns/1ps
`include "atc_regs.svh"
module atc_core_tb;
  logic sys_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, int_global_en;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [2:0] int_ack;
  logic awready, wready, bvalid, arready, rvalid, irq, fclk, lock, pen, plow;
  logic [1:0] bresp, rresp, rs;
  logic a, a_oe, a_n, a_n_oe, b, b_oe, b_n, b_n_oe;
  logic [7:0] v, c1, t1;
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_fail, checks_done, seed, hi, hn, ov;
  atc_core atc_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fast_peripheral_clock(fclk), .pll_locked(lock), .pll_enable(pen),
    .pll_low_speed(plow), .int_global_en(int_global_en), .int_ack(int_ack), .irq(irq),
    .wave_out_a(a), .wave_out_a_oe(a_oe), .wave_out_a_n(a_n), .wave_out_a_n_oe(a_n_oe),
    .wave_out_b(b), .wave_out_b_oe(b_oe), .wave_out_b_n(b_n), .wave_out_b_n_oe(b_n_oe));
  atc_pll_model atc_pll_model_i (.pll_enable(pen), .pll_low_speed(plow),
    .fast_peripheral_clock(fclk), .pll_locked(lock));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input logic [31:0] got, input int lo, input int hi_);
    checks_done++;
    if ((got >= lo && got <= hi_) !== 1'b1) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi_);
    end
  endtask : rng
  task automatic tmo(input int k);
    if (k >= 200) begin
      n_fail++;
      complete_run();
    end
  endtask : tmo
  // Channels are released independently as each is taken
  task automatic wr(input logic [5:0] ad, input logic [7:0] d, output logic [1:0] r);
    int k;
    logic ta, tw, tb;
    @(posedge sys_clk);
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (ta === 1'b1) awvalid <= 1'b0;
      if (tw === 1'b1) wvalid <= 1'b0;
      if (tb === 1'b1) break;
    end
    bready <= 1'b0;
    tmo(k);
  endtask : wr
  task automatic rd(input logic [5:0] ad, output logic [7:0] d, output logic [1:0] r);
    int k;
    logic ta, tr;
    @(posedge sys_clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge sys_clk);
      if (ta === 1'b1) arvalid <= 1'b0;
      if (tr === 1'b1) break;
    end
    rready <= 1'b0;
    tmo(k);
  endtask : rd
  function automatic int ticks(input int cyc, input int sel);
    return (sel == 0) ? 0 : cyc >> (sel - 1);
  endfunction : ticks
  function automatic int fast_ticks(input int cyc, input int low);
    return cyc * 8 / (low ? 80 : 40);
  endfunction : fast_ticks
  // Count advance over n spans of 50 cycles, optionally with prescaler resets between
  task automatic rate(input int n, input int exp, input bit psr);
    logic [7:0] x0, x1, dd;
    // Clear first, then let ticks of the old setting drain past the count delay
    if (psr) wr(`ATC_OFF_GCTRL, 8'h02, rs);
    repeat (4) @(posedge sys_clk);
    rd(`ATC_OFF_CNT, x0, rs);
    repeat (n) begin
      repeat (50) @(posedge sys_clk);
      if (psr) wr(`ATC_OFF_GCTRL, 8'h02, rs);
    end
    rd(`ATC_OFF_CNT, x1, rs);
    dd = x1 - x0;
    rng(dd, exp > 2 ? exp - 2 : 0, exp == 0 ? 0 : exp + 2);
  endtask : rate
  task automatic meas(input logic ch, input int n);
    hi = 0;
    hn = 0;
    ov = 0;
    repeat (n) begin
      @(negedge sys_clk);
      hi += ((ch ? b : a) === 1'b1);
      hn += ((ch ? b_n : a_n) === 1'b1);
      ov += ((ch ? b & b_n : a & a_n) === 1'b1);
    end
  endtask : meas
  initial begin
    seed = 90568;
    n_fail = 0;
    checks_done = 0;
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, int_global_en} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    int_ack = '0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(6'(i * 4), v, rs);
      chk(v, rv[i]);
      chk(rs, `ATC_RESP_OKAY);
    end
    rd(6'h24, v, rs);
    chk({v, 6'h0, rs}, {8'h00, 6'h0, `ATC_RESP_SLVERR});
    wr(6'h02, 8'h55, rs);
    chk(rs, `ATC_RESP_SLVERR);
    repeat (6) begin
      for (int j = 0; j < 3; j++) begin
        t1 = 8'($random(seed));
        wr(6'(8 + 4 * j), t1, rs);
        rd(6'(8 + 4 * j), v, rs);
        chk(v, t1);
      end
    end
    wr(`ATC_OFF_CTRL, 8'hA5, rs);
    rd(`ATC_OFF_CTRL, v, rs);
    chk(v, 8'hA5);
    wr(`ATC_OFF_GCTRL, 8'h72, rs);
    rd(`ATC_OFF_GCTRL, v, rs);
    chk(v, 8'h70);
    wr(`ATC_OFF_GCTRL, 8'h00, rs);
    wr(`ATC_OFF_TOP, 8'hFF, rs);
    for (int s = 0; s < 6; s++) begin
      wr(`ATC_OFF_CTRL, 8'(s), rs);
      // Snapshots lie three cycles further apart than the spans
      rate(1 << s, ticks((50 << s) + 3, s), 1'b0);
    end
    // Resets every ~55 cycles keep a /128 prescaler from ever firing
    wr(`ATC_OFF_CTRL, 8'h08, rs);
    rate(12, 0, 1'b1);
    wr(`ATC_OFF_CNT, 8'h00, rs);
    wr(`ATC_OFF_CMPA, 8'h40, rs);
    wr(`ATC_OFF_CMPB, 8'h80, rs);
    wr(`ATC_OFF_MASK, 8'h07, rs);
    wr(`ATC_OFF_CTRL, 8'h11, rs);
    repeat (300) @(posedge sys_clk);
    chk({a_oe, a_n_oe, b_n_oe}, 3'b100);
    wr(`ATC_OFF_CTRL, 8'h10, rs);
    repeat (4) @(posedge sys_clk);
    rd(`ATC_OFF_FLAG, v, rs);
    chk(v, 8'h07);
    chk(irq, 1'b0);
    int_global_en <= 1'b1;
    @(negedge sys_clk);
    chk(irq, 1'b1);
    @(posedge sys_clk);
    int_ack <= 3'b001;
    @(posedge sys_clk);
    int_ack <= 3'b000;
    rd(`ATC_OFF_FLAG, v, rs);
    chk(v, 8'h06);
    wr(`ATC_OFF_FLAG, 8'h06, rs);
    rd(`ATC_OFF_FLAG, v, rs);
    chk({v, irq}, 9'h000);
    // Clear on top in normal mode: no wrap from top
    wr(`ATC_OFF_CTRL, 8'h00, rs);
    wr(`ATC_OFF_CNT, 8'h00, rs);
    wr(`ATC_OFF_TOP, 8'h30, rs);
    wr(`ATC_OFF_CTRL, 8'h81, rs);
    repeat (300) @(posedge sys_clk);
    wr(`ATC_OFF_FLAG, 8'h07, rs);
    repeat (300) @(posedge sys_clk);
    rd(`ATC_OFF_FLAG, v, rs);
    chk(v, 8'h00);
    repeat (4) begin
      rd(`ATC_OFF_CNT, v, rs);
      rng(v, 0, 8'h30);
    end
    for (int ch = 0; ch < 2; ch++) begin
      wr(`ATC_OFF_CTRL, 8'h00, rs);
      wr(`ATC_OFF_GCTRL, 8'h00, rs);
      // Start below any new top, or the first pass runs on to FF
      wr(`ATC_OFF_CNT, 8'h00, rs);
      t1 = 8'h20 + 8'($random(seed) & 63);
      c1 = 8'h01 + 8'($random(seed) & 31);
      wr(`ATC_OFF_TOP, t1, rs);
      wr(`ATC_OFF_CMPA, ch ? 8'hFF : c1, rs);
      wr(`ATC_OFF_CMPB, ch ? c1 : 8'hFF, rs);
      if (ch) wr(`ATC_OFF_GCTRL, 8'h50, rs);
      wr(`ATC_OFF_CTRL, ch ? 8'h01 : 8'h51, rs);
      repeat (3 * (t1 + 1)) @(posedge sys_clk);
      wr(`ATC_OFF_FLAG, 8'h07, rs);
      meas(ch[0], 4 * (t1 + 1));
      rng(hi, 4 * c1 - 4, 4 * c1);
      rng(hi + hn, 4 * t1, 4 * t1 + 4);
      chk(ov, 0);
      chk(ch ? b_n_oe : a_n_oe, 1'b1);
      rd(`ATC_OFF_FLAG, v, rs);
      chk(v, ch ? 8'h03 : 8'h05);
      rd(`ATC_OFF_CNT, v, rs);
      rng(v, 0, t1);
      wr(ch ? `ATC_OFF_CMPB : `ATC_OFF_CMPA, c1 + 8'h01, rs);
      rd(ch ? `ATC_OFF_CMPB : `ATC_OFF_CMPA, v, rs);
      chk(v, c1 + 8'h01);
    end
    wr(`ATC_OFF_GCTRL, 8'h00, rs);
    wr(`ATC_OFF_TOP, 8'hFF, rs);
    wr(`ATC_OFF_PLL, 8'h02, rs);
    chk(pen, 1'b1);
    // Settle time of 100 us before the first lock poll
    repeat (12500) @(posedge sys_clk);
    for (int k = 0; k <= 200; k++) begin
      tmo(k);
      rd(`ATC_OFF_PLL, v, rs);
      if (v[0] === 1'b1) break;
      repeat (20) @(posedge sys_clk);
    end
    wr(`ATC_OFF_PLL, 8'h06, rs);
    wr(`ATC_OFF_CTRL, 8'h01, rs);
    rate(8, fast_ticks(400, 0), 1'b0);
    wr(`ATC_OFF_PLL, 8'h0E, rs);
    chk(plow, 1'b1);
    rate(8, fast_ticks(400, 1), 1'b0);
    rd(`ATC_OFF_PLL, v, rs);
    chk(v, 8'h0F);
    complete_run();
  end
endmodule : atc_core_tb
